// File: inc/rsb_pkg.sv
// constants and types for the bus-shutdown and test-word select block
package rsb_pkg;
  // register word indices as printed, byte address is four times the index
  localparam int unsigned IDX_CFG = 1;
  localparam int unsigned IDX_STAT = 2;
  localparam int unsigned IDX_BITW_DEF = 'h14;
  localparam int unsigned IDX_BITW_ALT = 'h15;
  localparam int AW = 12;
  localparam logic [AW-1:0] ADDR_CFG = AW'(IDX_CFG * 4);
  localparam logic [AW-1:0] ADDR_STAT = AW'(IDX_STAT * 4);
  localparam logic [AW-1:0] ADDR_BITW_DEF = AW'(IDX_BITW_DEF * 4);
  localparam logic [AW-1:0] ADDR_BITW_ALT = AW'(IDX_BITW_ALT * 4);
  // configuration field positions
  localparam int CFG_SW_RESET = 15;
  localparam int CFG_ALT_SEL = 10;
  localparam int CFG_HOST_OPT = 9;
  localparam int CFG_SCOPE = 8;
  localparam int CFG_INH_B = 1;
  localparam int CFG_INH_A = 0;
  localparam logic [15:0] CFG_WR_MASK = 16'h0703;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // default test word: shutdown state in 15:12, host bits 11:2, inhibits 1:0
  localparam int BITW_SHUT_LSB = 12;
  localparam logic [15:0] BITW_DEF_WR_MASK = 16'h0ffc;
  localparam logic [15:0] BITW_RESET = 16'h0000;
  // shutdown state bit positions
  localparam int SH_A_TX = 3;
  localparam int SH_A_RX = 2;
  localparam int SH_B_TX = 1;
  localparam int SH_B_RX = 0;
  // mode codes
  localparam logic [4:0] MC_SHUT = 5'h04;
  localparam logic [4:0] MC_OVER = 5'h05;
  localparam logic [4:0] MC_RESET = 5'h08;
  localparam logic [4:0] MC_TEST = 5'h13;
  localparam logic [4:0] MC_SEL_SHUT = 5'h14;
  localparam logic [4:0] MC_SEL_OVER = 5'h15;
  localparam logic BUS_A = 1'b0;
  localparam logic [15:0] STATUS_REPLY = 16'h0000;

  typedef struct packed {
    logic valid;
    logic bus;
    logic [4:0] code;
  } rsb_mode_cmd_t;

  typedef struct packed {
    logic shut_all;
    logic over_all;
    logic reset_rt;
    logic test_word;
    logic shut_sel;
    logic over_sel;
  } rsb_dec_t;

  typedef struct packed {
    logic tx_a;
    logic rx_a;
    logic tx_b;
    logic rx_b;
  } rsb_bus_en_t;

  typedef enum logic [1:0] {
    RSB_IDLE = 2'b01,
    RSB_REPLY = 2'b10
  } rsb_state_t;
endpackage

// File: rtl/rsb_sync.sv
// two-flop synchroniser for pin inputs
module rsb_sync #(
  parameter int W = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// File: rtl/rsb_decode.sv
// mode code decoder for the shutdown and test-word commands
module rsb_decode
  import rsb_pkg::*;
(
  input rsb_pkg::rsb_mode_cmd_t cmd,
  output rsb_pkg::rsb_dec_t dec
);
  // one flag per handled code, qualified by the command strobe
  always_comb begin
    dec.shut_all = cmd.valid && (cmd.code == MC_SHUT);
    dec.over_all = cmd.valid && (cmd.code == MC_OVER);
    dec.reset_rt = cmd.valid && (cmd.code == MC_RESET);
    dec.test_word = cmd.valid && (cmd.code == MC_TEST);
    dec.shut_sel = cmd.valid && (cmd.code == MC_SEL_SHUT);
    dec.over_sel = cmd.valid && (cmd.code == MC_SEL_OVER);
  end
endmodule

// File: rtl/rsb_top.sv
// bus shutdown handling and test-word select with apb registers
module rsb_top
  import rsb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rsb_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input rsb_pkg::rsb_mode_cmd_t mode_cmd,
  input wire logic bus_a_transmit_inhibit,
  input wire logic bus_b_transmit_inhibit,
  output rsb_pkg::rsb_bus_en_t bus_en,
  output logic reply_valid,
  output logic reply_is_data,
  output logic [15:0] reply_word
);
  import rsb_pkg::*;

  logic [15:0] cfg_r, cfg_nxt;
  logic [15:0] bitw_host_r, bitw_host_nxt;
  logic [15:0] bitw_alt_r, bitw_alt_nxt;
  logic [3:0] shut_r, shut_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [15:0] reply_word_r, reply_word_nxt;
  logic reply_is_data_r, reply_is_data_nxt;
  rsb_state_t state_r, state_nxt;
  rsb_dec_t dec;
  logic [1:0] pin_inh;
  logic inh_a, inh_b;
  logic host_opt, scope_tx_only, alt_sel;
  logic do_shut, do_over, do_clear, sw_reset;
  logic [3:0] target;
  logic [15:0] bitw_default;
  logic setup, wr_access, addr_ok;

  rsb_decode u_dec (
    .cmd(mode_cmd),
    .dec(dec)
  );

  // inhibit pins come from outside the clock domain
  rsb_sync #(.W(2)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({bus_b_transmit_inhibit, bus_a_transmit_inhibit}),
    .q(pin_inh)
  );

  // configuration fields and host-driven inhibits
  assign host_opt = cfg_r[CFG_HOST_OPT];
  assign scope_tx_only = cfg_r[CFG_SCOPE];
  assign alt_sel = cfg_r[CFG_ALT_SEL];
  assign inh_a = cfg_r[CFG_INH_A] | pin_inh[0];
  assign inh_b = cfg_r[CFG_INH_B] | pin_inh[1];

  // apb phase decode
  assign setup = psel && !penable;
  assign wr_access = psel && penable && pwrite;
  assign addr_ok = (paddr == ADDR_CFG) || (paddr == ADDR_STAT) ||
                   (paddr == ADDR_BITW_DEF) || (paddr == ADDR_BITW_ALT);
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;
  assign sw_reset = wr_access && (paddr == ADDR_CFG) && pwdata[CFG_SW_RESET];

  // default test word: device shutdown state over host bits and inhibits
  assign bitw_default = {shut_r, bitw_host_r[11:2], inh_b, inh_a};

  // shutdown command qualification
  always_comb begin
    do_shut = dec.shut_all || (dec.shut_sel && !host_opt);
    do_over = dec.over_all || (dec.over_sel && !host_opt);
    do_clear = dec.reset_rt || sw_reset;
    // the bus that did not carry the command is the one acted upon
    if (mode_cmd.bus == BUS_A) begin
      target = 4'b0011;
    end else begin
      target = 4'b1100;
    end
  end

  // shutdown state next value; a shutdown in the same cycle as a clear wins
  always_comb begin
    shut_nxt = shut_r;
    if (do_clear) begin
      shut_nxt = '0;
    end
    if (do_shut) begin
      if (scope_tx_only) begin
        shut_nxt = shut_nxt | (target & 4'b1010);
      end else begin
        shut_nxt = shut_nxt | target;
      end
    end
    if (do_over) begin
      shut_nxt = shut_nxt & ~target;
    end
  end

  // shutdown state register, held until a reactivation event
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shut_r <= '0;
    end else begin
      shut_r <= shut_nxt;
    end
  end

  // bus enables from shutdown state and inhibits
  always_comb begin
    bus_en.tx_a = !shut_r[SH_A_TX] && !inh_a;
    bus_en.rx_a = !shut_r[SH_A_RX];
    bus_en.tx_b = !shut_r[SH_B_TX] && !inh_b;
    bus_en.rx_b = !shut_r[SH_B_RX];
  end

  // register writes in the access cycle and read data capture in the setup cycle
  always_comb begin
    cfg_nxt = cfg_r;
    bitw_host_nxt = bitw_host_r;
    bitw_alt_nxt = bitw_alt_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup) begin
      pslverr_nxt = !addr_ok;
      case (paddr)
        ADDR_CFG: prdata_nxt = {16'h0000, cfg_r};
        ADDR_STAT: prdata_nxt = {28'h0000000, bus_en};
        ADDR_BITW_DEF: prdata_nxt = {16'h0000, bitw_default};
        ADDR_BITW_ALT: prdata_nxt = {16'h0000, bitw_alt_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
    if (wr_access) begin
      case (paddr)
        ADDR_CFG: cfg_nxt = pwdata[15:0] & CFG_WR_MASK;
        ADDR_BITW_DEF: bitw_host_nxt = pwdata[15:0] & BITW_DEF_WR_MASK;
        ADDR_BITW_ALT: bitw_alt_nxt = pwdata[15:0];
        default: cfg_nxt = cfg_r;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
      bitw_host_r <= BITW_RESET;
      bitw_alt_r <= BITW_RESET;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      bitw_host_r <= bitw_host_nxt;
      bitw_alt_r <= bitw_alt_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // reply sequencer: one reply cycle after each mode command seen in idle; a command during the reply cycle gets none
  always_comb begin
    state_nxt = state_r;
    reply_word_nxt = reply_word_r;
    reply_is_data_nxt = reply_is_data_r;
    case (state_r)
      RSB_IDLE: begin
        if (mode_cmd.valid) begin
          state_nxt = RSB_REPLY;
          reply_is_data_nxt = dec.test_word;
          if (!dec.test_word) begin
            reply_word_nxt = STATUS_REPLY;
          end else if (alt_sel) begin
            reply_word_nxt = bitw_alt_r;
          end else begin
            reply_word_nxt = bitw_default;
          end
        end
      end
      RSB_REPLY: begin
        state_nxt = RSB_IDLE;
      end
      default: begin
        state_nxt = RSB_IDLE;
      end
    endcase
  end

  // reply flops
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= RSB_IDLE;
      reply_word_r <= 16'h0000;
      reply_is_data_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      reply_word_r <= reply_word_nxt;
      reply_is_data_r <= reply_is_data_nxt;
    end
  end

  assign reply_valid = (state_r == RSB_REPLY);
  assign reply_word = reply_word_r;
  assign reply_is_data = reply_is_data_r;

  // checks on the shutdown and reply behaviour
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  default_word_a: assert property (
    (state_r == RSB_IDLE) && dec.test_word && !alt_sel
      |=> reply_valid && reply_is_data && (reply_word == $past(bitw_default)))
    else $error("default test word not sent");

  alt_word_a: assert property (
    (state_r == RSB_IDLE) && dec.test_word && alt_sel
      |=> reply_valid && (reply_word == $past(bitw_alt_r)))
    else $error("alternate test word not sent");

  status_bits_a: assert property (
    psel && penable && pwrite && (paddr == ADDR_BITW_DEF) && !mode_cmd.valid
      |=> $stable(bitw_default[15:12]))
    else $error("host write changed device status bits");

  shut_state_a: assert property (
    do_shut |=> bitw_default[15:12] != 4'h0)
    else $error("shutdown state not recorded in default word");

  inactive_only_a: assert property (
    dec.shut_all && mode_cmd.bus == BUS_A && !do_clear
      |=> shut_r[SH_B_TX] && (shut_r[3:2] == $past(shut_r[3:2])))
    else $error("shutdown touched the command bus");

  stay_shut_a: assert property (
    shut_r[SH_B_TX] && !do_over && !do_clear |=> shut_r[SH_B_TX] && !bus_en.tx_b)
    else $error("shut transmitter came back without reactivation");

  reactivate_a: assert property (
    do_clear && !do_shut |=> shut_r == 4'h0)
    else $error("reset did not reactivate transmitters");

  auto_sel_a: assert property (
    dec.shut_sel && !host_opt && !do_clear
      |=> ($past(mode_cmd.bus) == BUS_A) ? shut_r[SH_B_TX] : shut_r[SH_A_TX])
    else $error("selected shutdown not performed");

  host_opt_a: assert property (
    (dec.shut_sel || dec.over_sel) && host_opt && !do_clear |=> $stable(shut_r))
    else $error("selected command changed enables under host option");

  always_on_a: assert property (
    dec.shut_all && host_opt && !do_clear
      |=> ($past(mode_cmd.bus) == BUS_A) ? shut_r[SH_B_TX] : shut_r[SH_A_TX])
    else $error("code 4 ignored under host option");

  scope_sel_a: assert property (
    dec.shut_all && mode_cmd.bus == BUS_A && !do_clear
      |=> shut_r[SH_B_RX] == ($past(shut_r[SH_B_RX]) || !$past(scope_tx_only)))
    else $error("shutdown scope wrong");

  override_a: assert property (
    dec.over_all && mode_cmd.bus == BUS_A
      |=> shut_r[1:0] == 2'b00 ##0 bus_en.rx_b)
    else $error("override did not re-enable inactive bus");
endmodule

// File: tb/rsb_bc_model.sv
// bus controller model that sends one-cycle mode commands
module rsb_bc_model
  import rsb_pkg::*;
(
  input wire logic ref_clk,
  output rsb_pkg::rsb_mode_cmd_t mode_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial mode_cmd = '{valid: 1'b0, bus: 1'b1, code: 5'h1f};
  // pulse valid for one cycle; idle lines show the inverse of the last command
  task automatic issue(input logic bus, input logic [4:0] code);
    @(posedge ref_clk);
    mode_cmd <= '{valid: 1'b1, bus: bus, code: code};
    @(posedge ref_clk);
    mode_cmd <= '{valid: 1'b0, bus: ~bus, code: ~code};
  endtask
endmodule

// File: tb/tb_rsb_top.sv
// self-checking bench for the bus-shutdown and test-word select block
module tb_rsb_top;
  import rsb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] cfg;
    logic bus;
    logic [4:0] code;
    logic [3:0] en;
    logic is_data;
    logic [15:0] word;
  } rsb_row_t;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, reply_valid, reply_is_data;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic inh_a, inh_b, err;
  logic [15:0] reply_word;
  rsb_mode_cmd_t mode_cmd;
  rsb_bus_en_t bus_en;
  int bad_count = 0;
  int tests_run = 0;
  rsb_row_t rows [13] = '{
    '{16'h0000, 1'b0, MC_SHUT, 4'b1100, 1'b0, 16'h0000},
    '{16'h0000, 1'b0, MC_TEST, 4'b1100, 1'b1, 16'h3000},
    '{16'h0400, 1'b0, MC_TEST, 4'b1100, 1'b1, 16'ha5c3},
    '{16'h0000, 1'b0, MC_OVER, 4'b1111, 1'b0, 16'h0000},
    '{16'h0100, 1'b1, MC_SEL_SHUT, 4'b0111, 1'b0, 16'h0000},
    '{16'h0000, 1'b1, MC_TEST, 4'b0111, 1'b1, 16'h8000},
    '{16'h0200, 1'b1, MC_SEL_OVER, 4'b0111, 1'b0, 16'h0000},
    '{16'h0200, 1'b1, MC_OVER, 4'b1111, 1'b0, 16'h0000},
    '{16'h0200, 1'b0, MC_SEL_SHUT, 4'b1111, 1'b0, 16'h0000},
    '{16'h0200, 1'b0, MC_SHUT, 4'b1100, 1'b0, 16'h0000},
    '{16'h0000, 1'b0, MC_RESET, 4'b1111, 1'b0, 16'h0000},
    '{16'h0000, 1'b1, MC_SEL_SHUT, 4'b0011, 1'b0, 16'h0000},
    '{16'h0000, 1'b1, MC_SEL_OVER, 4'b1111, 1'b0, 16'h0000}
  };

  rsb_top dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mode_cmd(mode_cmd), .bus_a_transmit_inhibit(inh_a),
    .bus_b_transmit_inhibit(inh_b), .bus_en(bus_en), .reply_valid(reply_valid),
    .reply_is_data(reply_is_data), .reply_word(reply_word));
  rsb_bc_model bc_u (.ref_clk(ref_clk), .mode_cmd(mode_cmd));

  // 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // compare and count
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // send a command and look at the reply cycle
  task automatic cmd(input rsb_row_t r);
    bc_u.issue(r.bus, r.code);
    #1;
    chk("reply_valid", 32'(reply_valid), 32'h1);
    chk("reply_is_data", 32'(reply_is_data), 32'(r.is_data));
    chk("reply_word", 32'(reply_word), 32'(r.word));
    chk("bus_en", 32'(bus_en), 32'(r.en));
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    wrap_up();
  end

  initial begin
    {rst_n, psel, penable, pwrite, inh_a, inh_b} = '0;
    paddr = '0;
    pwdata = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("en_reset", 32'(bus_en), 32'hf);
    apb(1'b1, ADDR_BITW_ALT, 32'h0000a5c3);
    // table of mode commands against configuration
    foreach (rows[i]) begin
      apb(1'b1, ADDR_CFG, 32'(rows[i].cfg));
      cmd(rows[i]);
    end
    // software reset clears a shutdown
    cmd(rows[0]);
    apb(1'b1, ADDR_CFG, 32'h00008000);
    #1 chk("en_swrst", 32'(bus_en), 32'hf);
    apb(1'b0, ADDR_CFG, '0);
    chk("cfg_rd", rd, 32'h0);
    chk("cfg_err", 32'(err), 32'h0);
    // reset pin clears a shutdown and the alternate word
    cmd(rows[0]);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1 chk("en_mr", 32'(bus_en), 32'hf);
    apb(1'b0, ADDR_BITW_ALT, '0);
    chk("alt_rst", rd, 32'h0);
    // host inhibits by pin and by register
    inh_a <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1 chk("en_pin_a", 32'(bus_en), 32'h7);
    @(posedge ref_clk);
    inh_a <= 1'b0;
    apb(1'b1, ADDR_CFG, 32'h00000202);
    #1 chk("en_cfg_b", 32'(bus_en), 32'hd);
    apb(1'b0, ADDR_STAT, '0);
    chk("stat_rd", rd, 32'h0000000d);
    apb(1'b1, ADDR_CFG, '0);
    // default word keeps device bits read-only
    apb(1'b1, ADDR_BITW_DEF, 32'h0000ffff);
    apb(1'b0, ADDR_BITW_DEF, '0);
    chk("def_word", rd, 32'h00000ffc);
    // unmapped address
    apb(1'b0, 12'hff0, '0);
    chk("unmapped_err", 32'(err), 32'h1);
    chk("unmapped_rd", rd, 32'h0);
    wrap_up();
  end
endmodule
